// ==== scg_clock_ctrl.sv ====
// System clock controller with noise guard and APB register file
`timescale 1ns/100ps
`default_nettype none

module scg_clock_ctrl
  import scg_pkg::*;
#(
  parameter int unsigned WARM_MID = WARM_MID_TICKS,
  parameter int unsigned WARM_LONG = WARM_LONG_TICKS
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_osc_tick,
  input wire logic low_osc_tick,
  input wire logic quadrupled_tick,
  input wire logic [1:0] halt_state,
  input wire logic bus_wr_strobe,
  input wire logic [23:0] bus_wr_addr,
  output logic high_osc_enable,
  output logic low_osc_enable,
  output logic high_osc_drive,
  output logic low_osc_drive,
  output logic external_clock_in,
  output logic display_clock_source,
  output logic quad_run,
  output logic [7:0] quad_trim,
  output logic state_clock_en,
  output logic base_fast_en,
  output logic prescale_en,
  output logic clock_out_pin,
  output logic guard_violation_irq,
  output logic rom_write_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] sys0_q;
  logic [7:0] sys1_q;
  logic [7:0] sys2_q;
  logic [7:0] noise_q;
  logic [7:0] romdet_q;
  logic [7:0] qctl_q;
  logic [7:0] trim_q;
  logic [7:0] portd_q;
  logic protect_q;
  scg_key_e key_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic setup;
  logic wr_do;
  logic mapped;
  logic guarded;
  logic wr_ok;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rd_val;
  logic warm_on_low_q;
  logic sel_low_q;
  logic phase_q;
  logic state_en_q;
  logic gear_tick;
  logic hsrc_tick;
  logic base_fast_clock_tick;
  logic [1:0] pre_a_q;
  logic [5:0] pre_b_q;
  logic pre_en_q;
  logic low_lvl_q;
  logic clk_out_q;
  logic viol_q;
  logic rom_irq_q;
  logic quad_run_q;
  logic [2:0] region_hit;
  logic [2:0] flag_d;
  logic [16:0] warm_limit;

  scg_tmr_if warm_if();
  scg_tmr_if lock_if();

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = paddr[9:2];
  assign wbyte = pwdata[7:0];
  assign setup = psel && !penable && !pready_q;
  assign wr_do = psel && penable && pready_q && pwrite && !pslverr_q;

  // Map check; the upper address bits must be zero
  always_comb
  begin
    mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    unique case (idx)
      IDX_SYS_CTRL0, IDX_SYS_CTRL1, IDX_SYS_CTRL2, IDX_NOISE_CONTROL,
      IDX_PROTECT_KEY_ONE, IDX_PROTECT_KEY_TWO, IDX_ROM_WRITE_DETECT,
      IDX_QUADRUPLER_CONTROL, IDX_MULTIPLIER_TRIM, IDX_PORT_D5_CTRL: ;
      default: mapped = 1'b0;
    endcase
  end

  // Registers under the write guard
  always_comb
  begin
    unique case (idx)
      IDX_SYS_CTRL0, IDX_SYS_CTRL1, IDX_SYS_CTRL2, IDX_NOISE_CONTROL,
      IDX_ROM_WRITE_DETECT, IDX_QUADRUPLER_CONTROL,
      IDX_MULTIPLIER_TRIM: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  end

  assign wr_ok = wr_do && !(guarded && protect_q);

  // Read view; status bits show live state, keys read as zero
  always_comb
  begin
    rd_val = 8'h00;
    unique case (idx)
      IDX_SYS_CTRL0:
        rd_val = {sys0_q[7:3], warm_if.busy, sys0_q[1:0]};
      IDX_SYS_CTRL1: rd_val = {4'h0, sys1_q[3:0]};
      IDX_SYS_CTRL2: rd_val = {1'b0, sys2_q[6:0]};
      IDX_NOISE_CONTROL: rd_val = {protect_q, noise_q[6:0]};
      IDX_ROM_WRITE_DETECT: rd_val = {1'b0, romdet_q[6:4], 1'b0, romdet_q[2:0]};
      IDX_QUADRUPLER_CONTROL:
        rd_val = {qctl_q[7:6], lock_if.busy, qctl_q[4], 4'h0};
      IDX_MULTIPLIER_TRIM: rd_val = trim_q;
      IDX_PORT_D5_CTRL: rd_val = {6'h00, portd_q[1:0]};
      default: rd_val = 8'h00;
    endcase
  end

  // Answer one cycle after setup, so the access phase never waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup)
        prdata_q <= (mapped && !pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Oscillator enables act alone; quadrupler order is left to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys0_q <= RST_SYS_CTRL0;
      sys1_q <= RST_SYS_CTRL1;
      sys2_q <= RST_SYS_CTRL2;
      portd_q <= RST_PORT_D5_CTRL;
      trim_q <= RST_MULTIPLIER_TRIM;
    end
    else if (wr_ok)
    begin
      unique case (idx)
        IDX_SYS_CTRL0: sys0_q <= {wbyte[7:3], 1'b0, wbyte[1:0]};
        IDX_SYS_CTRL1: sys1_q <= {4'h0, wbyte[3:0]};
        IDX_SYS_CTRL2: sys2_q <= {1'b0, wbyte[6:0]};
        IDX_PORT_D5_CTRL: portd_q <= {6'h00, wbyte[1:0]};
        IDX_MULTIPLIER_TRIM: trim_q <= wbyte;
        default: ;
      endcase
    end
  end

  // Noise control keeps its stored bits; the protect bit lives apart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      noise_q <= RST_NOISE_CONTROL;
    else if (wr_ok && idx == IDX_NOISE_CONTROL)
      noise_q <= {1'b0, wbyte[6:0]};
  end

  // Each write applies as given; stop-after-switch takes two writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      qctl_q <= RST_QUADRUPLER_CONTROL;
      quad_run_q <= 1'b0;
    end
    else if (wr_ok && idx == IDX_QUADRUPLER_CONTROL)
    begin
      qctl_q <= {wbyte[7:6], 1'b0, wbyte[4], 4'h0};
      quad_run_q <= wbyte[7:6] != QA_STOP; // Kept in a flop so the pin is clean
    end
  end

  // ----------------------------------------------------------------
  // Write guard double key
  // ----------------------------------------------------------------
  // Any foreign write inside a key pair breaks it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_q <= KS_IDLE;
      protect_q <= 1'b0;
    end
    else if (wr_do)
    begin
      unique case (key_q)
        KS_IDLE:
          key_q <= (idx == IDX_PROTECT_KEY_ONE && wbyte == KEY_A) ? KS_HALF : KS_IDLE;
        KS_HALF:
          key_q <= (idx == IDX_PROTECT_KEY_TWO && wbyte == KEY_B) ? KS_FIRST
                                                                  : KS_IDLE;
        KS_FIRST:
          if (idx == IDX_PROTECT_KEY_ONE)
            key_q <= (wbyte == KEY_B) ? KS_SECOND : KS_IDLE;
        KS_SECOND:
        begin
          key_q <= KS_IDLE;
          if (idx == IDX_PROTECT_KEY_TWO && wbyte == KEY_A)
            protect_q <= !protect_q;
        end
      endcase
    end
  end

  // One-cycle pulse on each blocked write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      viol_q <= 1'b0;
    else
      viol_q <= wr_do && guarded && protect_q;
  end

  // ----------------------------------------------------------------
  // ROM write detection
  // ----------------------------------------------------------------
  // Region i covers the quarter whose top bits equal i+1
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_region
      assign region_hit[gi] = bus_wr_strobe && romdet_q[B_DETECT_EN_MSB - gi]
                              && bus_wr_addr[23:22] == 2'(gi + 1);
      // Hardware set wins over a clear written in the same cycle
      assign flag_d[gi] = region_hit[gi] || (romdet_q[B_WRITE_FLAG_MSB - gi]
                          && !(wr_ok && idx == IDX_ROM_WRITE_DETECT
                               && !wbyte[B_WRITE_FLAG_MSB - gi]));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      romdet_q <= RST_ROM_WRITE_DETECT;
      rom_irq_q <= 1'b0;
    end
    else
    begin
      if (wr_ok && idx == IDX_ROM_WRITE_DETECT)
        romdet_q[6:4] <= wbyte[6:4];
      romdet_q[2:0] <= {flag_d[0], flag_d[1], flag_d[2]};
      rom_irq_q <= |region_hit;
    end
  end

  // ----------------------------------------------------------------
  // Warm-up and lock-up timers
  // ----------------------------------------------------------------
  // Reserved length code 00 is run as the longest wait
  always_comb
  begin
    unique case (sys2_q[B_WARMUP_LEN_LSB +: 2])
      2'h1: warm_limit = 17'(WARM_SHORT_TICKS);
      2'h2: warm_limit = 17'(WARM_MID);
      default: warm_limit = 17'(WARM_LONG);
    endcase
  end

  // The oscillator not feeding the state clock is the one warming up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warm_on_low_q <= 1'b0;
    else if (warm_if.start)
      warm_on_low_q <= !sys1_q[B_CLOCK_SOURCE_SELECT];
  end

  assign warm_if.start = wr_ok && idx == IDX_SYS_CTRL0 && wbyte[B_WARMUP_RUN];
  assign warm_if.tick = warm_on_low_q ? low_osc_tick : high_osc_tick;
  assign warm_if.limit = warm_limit;
  scg_tick_timer u_warm (.clk(pclk), .rst_n(presetn), .t(warm_if));

  // Lock-up runs on the raw high clock after an action 01 write
  assign lock_if.start = wr_ok && idx == IDX_QUADRUPLER_CONTROL
                         && wbyte[7:6] == QA_LOCK;
  assign lock_if.tick = high_osc_tick;
  assign lock_if.limit = qctl_q[B_QUAD_LOCK_TIME] ? 17'(LOCK_SHORT_TICKS)
                                                  : 17'(LOCK_LONG_TICKS);
  scg_tick_timer u_lock (.clk(pclk), .rst_n(presetn), .t(lock_if));

  // ----------------------------------------------------------------
  // Clock gear and state clock
  // ----------------------------------------------------------------
  // Quadrupled clock feeds the gear only in action 10
  assign hsrc_tick = (qctl_q[7:6] == QA_QUAD) ? quadrupled_tick
                                              : high_osc_tick;

  scg_gear_div u_gear (
    .clk(pclk),
    .rst_n(presetn),
    .src_tick(hsrc_tick),
    .gear(sys1_q[B_GEAR_LSB +: 3]),
    .tick_out(gear_tick)
  );

  assign base_fast_clock_tick = sel_low_q ? low_osc_tick : gear_tick;

  // Source swap only at the end of a whole state cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_low_q <= 1'b0;
      phase_q <= 1'b0;
      state_en_q <= 1'b0;
    end
    else
    begin
      state_en_q <= base_fast_clock_tick && phase_q;
      if (base_fast_clock_tick)
      begin
        phase_q <= !phase_q;
        if (phase_q)
          sel_low_q <= sys1_q[B_CLOCK_SOURCE_SELECT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler source
  // ----------------------------------------------------------------
  // Reserved source codes give no prescaler ticks at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_a_q <= 2'h0;
      pre_b_q <= 6'h00;
      pre_en_q <= 1'b0;
    end
    else
    begin
      if (base_fast_clock_tick)
        pre_a_q <= pre_a_q + 2'h1;
      if (hsrc_tick)
        pre_b_q <= pre_b_q + 6'h01;
      unique case (sys0_q[B_PRESCALER_LSB +: 2])
        PS_BASE: pre_en_q <= base_fast_clock_tick && pre_a_q == 2'h3;
        PS_HIGH16: pre_en_q <= hsrc_tick && pre_b_q == 6'h3F;
        default: pre_en_q <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  // Deep idle and stop freeze the pin at its present level only when it shows the state clock phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_lvl_q <= 1'b0;
      clk_out_q <= 1'b0;
    end
    else
    begin
      if (low_osc_tick)
        low_lvl_q <= !low_lvl_q;
      if (!portd_q[B_PORT_D5_FUNCTION])
        clk_out_q <= portd_q[B_PORT_D5_DATA];
      else if (!sys2_q[B_CLOCK_OUT_SELECT])
        clk_out_q <= low_lvl_q;
      else if (halt_state != HS_DEEP_IDLE && halt_state != HS_STOP)
        clk_out_q <= phase_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign high_osc_enable = sys0_q[B_HIGH_OSC_ENABLE];
  assign low_osc_enable = sys0_q[B_LOW_OSC_ENABLE];
  assign high_osc_drive = noise_q[B_HIGH_OSC_DRIVE];
  assign low_osc_drive = noise_q[B_LOW_OSC_DRIVE];
  assign external_clock_in = noise_q[B_EXTERNAL_CLOCK_IN];
  assign display_clock_source = noise_q[B_DISPLAY_CLOCK_SOURCE];
  assign quad_run = quad_run_q;
  assign quad_trim = trim_q;
  assign state_clock_en = state_en_q;
  assign base_fast_en = gear_tick;
  assign prescale_en = pre_en_q;
  assign clock_out_pin = clk_out_q;
  assign guard_violation_irq = viol_q;
  assign rom_write_irq = rom_irq_q;
endmodule
`default_nettype wire

// ==== scg_pkg.sv ====
// Constants shared by the system clock and noise guard block
package scg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SYS_CTRL0 = 8'hE0;
  localparam logic [7:0] IDX_SYS_CTRL1 = 8'hE1;
  localparam logic [7:0] IDX_SYS_CTRL2 = 8'hE2;
  localparam logic [7:0] IDX_NOISE_CONTROL = 8'hE3;
  localparam logic [7:0] IDX_PROTECT_KEY_ONE = 8'hE4;
  localparam logic [7:0] IDX_PROTECT_KEY_TWO = 8'hE5;
  localparam logic [7:0] IDX_ROM_WRITE_DETECT = 8'hE6;
  localparam logic [7:0] IDX_QUADRUPLER_CONTROL = 8'hE8;
  localparam logic [7:0] IDX_MULTIPLIER_TRIM = 8'hE9;
  localparam logic [7:0] IDX_PORT_D5_CTRL = 8'hF0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SYS_CTRL0 = 8'hA0;
  localparam logic [7:0] RST_SYS_CTRL1 = 8'h04;
  localparam logic [7:0] RST_SYS_CTRL2 = 8'h2C;
  localparam logic [7:0] RST_NOISE_CONTROL = 8'h23;
  localparam logic [7:0] RST_ROM_WRITE_DETECT = 8'h00;
  localparam logic [7:0] RST_QUADRUPLER_CONTROL = 8'h00;
  localparam logic [7:0] RST_MULTIPLIER_TRIM = 8'h13;
  localparam logic [7:0] RST_PORT_D5_CTRL = 8'h00;
  localparam logic [2:0] RST_GEAR_SHIFT = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_HIGH_OSC_ENABLE = 7;
  localparam int B_LOW_OSC_ENABLE = 6;
  localparam int B_WARMUP_RUN = 2;
  localparam int B_PRESCALER_LSB = 0;
  localparam int B_CLOCK_SOURCE_SELECT = 3;
  localparam int B_GEAR_LSB = 0;
  localparam int B_CLOCK_OUT_SELECT = 6;
  localparam int B_WARMUP_LEN_LSB = 4;
  localparam int B_PROTECT = 7;
  localparam int B_DISPLAY_CLOCK_SOURCE = 6;
  localparam int B_EXTERNAL_CLOCK_IN = 2;
  localparam int B_HIGH_OSC_DRIVE = 1;
  localparam int B_LOW_OSC_DRIVE = 0;
  localparam int B_DETECT_EN_MSB = 6;
  localparam int B_WRITE_FLAG_MSB = 2;
  localparam int B_QUAD_ACTION_LSB = 6;
  localparam int B_QUAD_LOCK_FLAG = 5;
  localparam int B_QUAD_LOCK_TIME = 4;
  localparam int B_PORT_D5_FUNCTION = 1;
  localparam int B_PORT_D5_DATA = 0;

  // ----------------------------------------------------------------
  // Codes, keys and timing counts (oscillator ticks)
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_A = 8'h5A;
  localparam logic [7:0] KEY_B = 8'hA5;
  localparam logic [1:0] QA_STOP = 2'h0;
  localparam logic [1:0] QA_LOCK = 2'h1;
  localparam logic [1:0] QA_QUAD = 2'h2;
  localparam logic [1:0] PS_BASE = 2'h0;
  localparam logic [1:0] PS_HIGH16 = 2'h2;
  localparam logic [1:0] HS_DEEP_IDLE = 2'h2;
  localparam logic [1:0] HS_STOP = 2'h3;
  localparam int unsigned WARM_SHORT_TICKS = 256;
  localparam int unsigned WARM_MID_TICKS = 16384;
  localparam int unsigned WARM_LONG_TICKS = 65536;
  localparam int unsigned LOCK_LONG_TICKS = 4096;
  localparam int unsigned LOCK_SHORT_TICKS = 1024;
  localparam int unsigned TMR_W = 17;

  typedef enum logic [3:0] {
    KS_IDLE = 4'b0001,
    KS_HALF = 4'b0010,
    KS_FIRST = 4'b0100,
    KS_SECOND = 4'b1000
  } scg_key_e;

endpackage

// ==== scg_tmr_if.sv ====
// Control bundle between the block and one tick timer
`timescale 1ns/100ps
`default_nettype none
interface scg_tmr_if;
  logic start;
  logic tick;
  logic [16:0] limit;
  logic busy;
  modport ctl (output start, output tick, output limit, input busy);
  modport tmr (input start, input tick, input limit, output busy);
endinterface
`default_nettype wire

// ==== scg_tick_timer.sv ====
// Tick counting timer used for oscillator warm-up and lock-up
`timescale 1ns/100ps
`default_nettype none
module scg_tick_timer
  import scg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  scg_tmr_if.tmr t
);
  logic [TMR_W-1:0] cnt_q;
  logic busy_q;

  assign t.busy = busy_q;

  // Start clears the count; only ticks of the watched clock advance it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (t.start)
    begin
      cnt_q <= '0;
      busy_q <= 1'b1;
    end
    else if (busy_q && t.tick)
    begin
      if (cnt_q == t.limit - 17'h00001)
        busy_q <= 1'b0;
      cnt_q <= cnt_q + 17'h00001;
    end
  end
endmodule
`default_nettype wire

// ==== scg_gear_div.sv ====
// Clock gear divider producing base fast clock enable pulses
`timescale 1ns/100ps
`default_nettype none
module scg_gear_div
  import scg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic [2:0] gear,
  output logic tick_out
);
  logic [2:0] shift_q;
  logic [3:0] cnt_q;
  logic [2:0] shift_d;

  // Legal codes 000..100 map to shifts 0..4; others keep the old ratio
  always_comb
  begin
    shift_d = (gear <= 3'h4) ? gear : shift_q;
  end

  // Ratio only changes at a period boundary so no short pulse leaks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= RST_GEAR_SHIFT;
      cnt_q <= 4'h0;
      tick_out <= 1'b0;
    end
    else if (src_tick && cnt_q == 4'h0)
    begin
      shift_q <= shift_d;
      cnt_q <= 4'((5'h01 << shift_d) - 5'h01);
      tick_out <= 1'b1;
    end
    else
    begin
      if (src_tick)
        cnt_q <= cnt_q - 4'h1;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== scg_clock_ctrl_monitor.sv ====
// Port checker for the clock controller
`timescale 1ns/100ps
`default_nettype none
module scg_clock_ctrl_checker
  import scg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_wr_strobe,
  input wire logic [23:0] bus_wr_addr,
  input wire logic high_osc_drive,
  input wire logic low_osc_drive,
  input wire logic display_clock_source,
  input wire logic quad_run,
  input wire logic state_clock_en,
  input wire logic guard_violation_irq,
  input wire logic rom_write_irq
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_done;
  logic rom_hit;
  // Completed write, and a bus write into a ROM region
  assign wr_done = psel && penable && pready && pwrite;
  assign rom_hit = bus_wr_strobe && (bus_wr_addr[23:22] != 2'h0);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  property p_err;
    s_setup and (paddr[9:2] == 8'hF1) |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_drv;
    $changed({high_osc_drive, low_osc_drive}) |-> $past(wr_done)
      && $past(paddr[9:2]) == IDX_NOISE_CONTROL;
  endproperty
  a_drv: assert property (p_drv) else $error("drive moved without write");
  property p_disp;
    $changed(display_clock_source) |-> $past(wr_done)
      && $past(paddr[9:2]) == IDX_NOISE_CONTROL;
  endproperty
  a_disp: assert property (p_disp) else $error("display source moved");
  property p_quad;
    $changed(quad_run) |-> $past(wr_done)
      && $past(paddr[9:2]) == IDX_QUADRUPLER_CONTROL;
  endproperty
  a_quad: assert property (p_quad) else $error("quadrupler moved");
  property p_gv;
    guard_violation_irq |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_gv: assert property (p_gv) else $error("violation without write");
  property p_gvp;
    guard_violation_irq |=> !guard_violation_irq;
  endproperty
  a_gvp: assert property (p_gvp) else $error("violation not a pulse");
  property p_rom;
    rom_write_irq |-> $past(rom_hit) || $past(rom_hit, 2);
  endproperty
  a_rom: assert property (p_rom) else $error("rom irq without write");
  property p_sce;
    state_clock_en |=> !state_clock_en;
  endproperty
  a_sce: assert property (p_sce) else $error("state clock too fast");
endmodule
bind scg_clock_ctrl scg_clock_ctrl_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .bus_wr_strobe, .bus_wr_addr, .high_osc_drive,
  .low_osc_drive, .display_clock_source, .quad_run, .state_clock_en,
  .guard_violation_irq, .rom_write_irq);
`default_nettype wire

// ==== test_system_clock_and_noise_guard.sv ====
// Self-checking bench for the clock controller
`timescale 1ns/100ps
`default_nettype none
module test_system_clock_and_noise_guard
  import scg_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hi_tick = 1'b0, lo_tick = 1'b0, bus_wr_strobe = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [23:0] bus_wr_addr = 24'h0;
  logic [1:0] tick_c = 2'h0;
  logic pready, pslverr, hoe, loe, hod, lod, dcs, qr, gv, rw, eci, sce, bfe, pe, cop;
  logic [7:0] qt;
  int num_errors = 0, comparisons = 0, gv_n = 0, rw_n = 0, cyc = 0;
  int bf_n = 0, sc_n = 0, pe_n = 0;
  scg_clock_ctrl #(.WARM_MID(32), .WARM_LONG(64)) i_scg_clock_ctrl (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .high_osc_tick(hi_tick), .low_osc_tick(lo_tick), .quadrupled_tick(1'b0),
    .halt_state(2'h0), .bus_wr_strobe, .bus_wr_addr, .high_osc_enable(hoe),
    .low_osc_enable(loe), .high_osc_drive(hod), .low_osc_drive(lod),
    .external_clock_in(eci), .display_clock_source(dcs), .quad_run(qr), .quad_trim(qt),
    .state_clock_en(sce), .base_fast_en(bfe), .prescale_en(pe), .clock_out_pin(cop),
    .guard_violation_irq(gv), .rom_write_irq(rw));
  // ----------------------------------------
  // Clock, oscillator ticks, pulse counts, timeout
  // ----------------------------------------
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // Both oscillators tick every fourth cycle, so warm-up length is exact
  always @(posedge pclk)
  begin
    tick_c <= tick_c + 2'h1;
    hi_tick <= (tick_c == 2'h3);
    lo_tick <= (tick_c == 2'h3);
    gv_n += (gv === 1'b1);
    rw_n += (rw === 1'b1);
    bf_n += (bfe === 1'b1);
    sc_n += (sce === 1'b1);
    pe_n += (pe === 1'b1);
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rc(input string n, input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(n, rdv, {24'h0, e});
  endtask
  task automatic strobe(input logic [23:0] a);
    bus_wr_strobe <= 1'b1;
    bus_wr_addr <= a;
    @(posedge pclk);
    bus_wr_strobe <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b);
    wr(IDX_PROTECT_KEY_ONE, a);
    wr(IDX_PROTECT_KEY_TWO, b);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rc("noise", IDX_NOISE_CONTROL, 8'h23);
    rc("romdet", IDX_ROM_WRITE_DETECT, 8'h00);
    rc("sys1", IDX_SYS_CTRL1, 8'h04);
    rc("trim", IDX_MULTIPLIER_TRIM, 8'h13);
    chk("levels", {hoe, loe, hod, lod, dcs, qr, eci, qt}, {6'b101100, 1'b0, 8'h13});
  endtask
  task automatic t_noise;
    wr(IDX_NOISE_CONTROL, 8'h60);
    chk("drives", {hod, lod, dcs}, 3'b001);
    wr(IDX_NOISE_CONTROL, 8'h23);
    apb(1'b0, 8'hF1, 8'h00);
    chk("unmapped", err, 1); // Refused address
    wr(IDX_SYS_CTRL0, 8'h60);
    chk("osc", {hoe, loe}, 2'b01);
    wr(IDX_SYS_CTRL0, 8'hA0);
    wr(IDX_PORT_D5_CTRL, 8'h01);
    @(posedge pclk);
    chk("pin", cop, 1);
    wr(IDX_PORT_D5_CTRL, 8'h00);
  endtask
  task automatic t_protect;
    keys(8'h5A, 8'hA5);
    keys(8'hA5, 8'h5A);
    rc("on", IDX_NOISE_CONTROL, 8'hA3);
    wr(IDX_NOISE_CONTROL, 8'h20);
    wr(IDX_PROTECT_KEY_ONE, 8'h5A);
    wr(IDX_ROM_WRITE_DETECT, 8'h70);
    wr(IDX_PROTECT_KEY_TWO, 8'hA5);
    keys(8'hA5, 8'h5A);
    rc("kept", IDX_NOISE_CONTROL, 8'hA3);
    chk("viol", gv_n, 2);
    keys(8'h5A, 8'hA5);
    keys(8'hA5, 8'h5A);
    rc("off", IDX_NOISE_CONTROL, 8'h23);
  endtask
  task automatic t_rom;
    wr(IDX_ROM_WRITE_DETECT, 8'h70);
    strobe(24'h400000);
    strobe(24'h800000);
    strobe(24'hC00000);
    strobe(24'h100000);
    rc("flags", IDX_ROM_WRITE_DETECT, 8'h77);
    chk("romirq", rw_n, 3);
    wr(IDX_ROM_WRITE_DETECT, 8'h00);
    strobe(24'h7FFFFF);
    rc("clear", IDX_ROM_WRITE_DETECT, 8'h00);
  endtask
  // Quadrupler handled in high-clock normal mode: switch back, then stop
  task automatic t_quad;
    wr(IDX_QUADRUPLER_CONTROL, 8'h50);
    rc("lock", IDX_QUADRUPLER_CONTROL, 8'h70);
    wr(IDX_QUADRUPLER_CONTROL, 8'hC0);
    chk("qrun", qr, 1);
    wr(IDX_QUADRUPLER_CONTROL, 8'h00);
    chk("qstop", qr, 0);
  endtask
  // Gear 000 with a dummy write after it; counts taken off the edge
  task automatic t_gear;
    int b, s, p;
    wr(IDX_SYS_CTRL1, 8'h00);
    wr(IDX_NOISE_CONTROL, 8'h23);
    repeat (80) @(posedge pclk);
    @(negedge pclk);
    b = bf_n;
    s = sc_n;
    p = pe_n;
    repeat (64) @(negedge pclk);
    chk("base", bf_n - b, 16);
    chk("state", sc_n - s, 8);
    chk("prescale", pe_n - p, 4);
    @(posedge pclk);
    wr(IDX_SYS_CTRL1, 8'h04);
  endtask
  task automatic t_warm;
    wr(IDX_SYS_CTRL0, 8'hA4);
    repeat (70) @(posedge pclk);
    rc("warm", IDX_SYS_CTRL0, 8'hA4);
    repeat (80) @(posedge pclk);
    rc("done", IDX_SYS_CTRL0, 8'hA0);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_noise();
    t_protect();
    t_rom();
    t_quad();
    t_gear();
    t_warm();
    finish_test();
  end
endmodule
`default_nettype wire
